// ===== sbb_map.svh
`ifndef SBB_MAP_SVH
`define SBB_MAP_SVH
// Instruction word widths and fields
`define SBB_IW_W      14
`define SBB_PTR_W     15
`define SBB_FADDR_HI  6
`define SBB_DEST_BIT  7
`define SBB_BIT_LO    7
`define SBB_BIT_HI    9
`define SBB_OFF_HI    8
`define SBB_OFF_W     9
`define SBB_NIB_HI    3
`define SBB_MSB       7
`define SBB_LSB       0
// Reset values and other constants
`define SBB_ACC_RST   8'h00
`define SBB_PTR_RST   15'h0000
`define SBB_ONE_PTR   15'h0001
`define SBB_ZERO8     8'h00
`define SBB_ONE8      8'h01
`define SBB_ZERO9     9'h000
// Timing of the redirect-filler cycle
`define SBB_FILL_CYC  1
`endif

// ===== sbb_pkg.sv
`default_nettype none
package sbb_pkg;
    // Operations decoded by fetch logic outside this block
    typedef enum logic [2:0] {
        SBB_OP_NONE,
        SBB_OP_ARITH_SHIFT_RIGHT_FILE,
        SBB_OP_ADD_WITH_CARRY_TO_FILE,
        SBB_OP_BIT_CLEAR_FILE,
        SBB_OP_BIT_TEST_SKIP_CLEAR,
        SBB_OP_BIT_TEST_SKIP_SET,
        SBB_OP_RELATIVE_JUMP
    } sbb_op_t;
    typedef enum logic {
        SBB_ST_RUN,
        SBB_ST_FILL
    } sbb_state_t;
endpackage : sbb_pkg
`default_nettype wire

// ===== sbb_alu.sv
`timescale 1ns/10ps
`default_nettype none
`include "sbb_map.svh"
// Pure datapath: result and flag values for one operation
module sbb_alu
    import sbb_pkg::*;
(
    input  wire sbb_op_t    op,
    input  wire logic [7:0] acc,
    input  wire logic [7:0] fdata,
    input  wire logic [2:0] bsel,
    input  wire logic       carry_in,
    output logic      [7:0] result,
    output logic            carry_out,
    output logic            nibble_out,
    output logic            bit_val
);
    logic [8:0] sum;
    logic [4:0] nib;
    // ---------------------------------------------
    // Operation results
    // ---------------------------------------------
    always_comb
    begin
        sum        = {1'b0, acc} + {1'b0, fdata} + {8'h00, carry_in};
        nib        = {1'b0, acc[`SBB_NIB_HI:0]} + {1'b0, fdata[`SBB_NIB_HI:0]}
                     + {4'h0, carry_in};
        result     = fdata;
        carry_out  = carry_in;
        nibble_out = nib[4];
        bit_val    = fdata[bsel];
        case (op)
            SBB_OP_ARITH_SHIFT_RIGHT_FILE:
            begin
                result    = {fdata[`SBB_MSB], fdata[`SBB_MSB:1]}; // RQ1
                carry_out = fdata[`SBB_LSB];                       // RQ1
            end
            SBB_OP_ADD_WITH_CARRY_TO_FILE:
            begin
                result    = sum[7:0];  // RQ4
                carry_out = sum[8];    // RQ4
            end
            SBB_OP_BIT_CLEAR_FILE:
            begin
                result = fdata & ~(`SBB_ONE8 << bsel); // RQ5
            end
            default:
            begin
                result = fdata;
            end
        endcase
    end
endmodule // sbb_alu
`default_nettype wire

// ===== sbb_core.sv
`timescale 1ns/10ps
`default_nettype none
`include "sbb_map.svh"
// Function
// [RQ1] Shift right, keep MSB, bit0 to carry
// [RQ2] Destination zero writes the accumulator
// [RQ3] Destination one writes back file register
// [RQ4] Add accumulator, file, carry; set flags
// [RQ5] Clear selected bit, others kept
// [RQ6] Skip-if-clear: skip when bit zero
// [RQ7] Skip-if-set: skip when bit one
// [RQ8] Jump to incremented pointer plus offset
// [RQ9] Relative jump always takes two cycles
// [RQ10] Redirect or true test adds filler cycle
// [RQ11] Bit/jump ops keep flags; failed skip one cycle
module sbb_core
    import sbb_pkg::*;
(
    input  wire logic                   core_clk,
    input  wire logic                   rst_b,
    input  wire logic                   instr_valid,
    input  wire sbb_op_t                instr_op,
    input  wire logic [`SBB_IW_W-1:0]   instr_word,
    input  wire logic [`SBB_PTR_W-1:0]  instr_pointer_in,
    input  wire logic [7:0]             file_rdata,
    output logic      [6:0]             file_addr,
    output logic                        file_we,
    output logic      [7:0]             file_wdata,
    output logic      [7:0]             acc,
    output logic                        carry,
    output logic                        nibble_overflow_flag,
    output logic                        zero,
    output logic      [`SBB_PTR_W-1:0]  instr_pointer,
    output logic                        instr_pointer_load,
    output logic                        discard_next,
    output logic                        stall_busy
);
    sbb_state_t            state_r, state_nxt;
    logic [7:0]            acc_r, acc_nxt;
    logic                  c_r, c_nxt, dc_r, dc_nxt, z_r, z_nxt;
    logic [`SBB_PTR_W-1:0] ptr_r, ptr_nxt;
    logic                  ld_r, ld_nxt, disc_r, disc_nxt;
    logic                  we_r, we_nxt;
    logic [7:0]            wd_r, wd_nxt;
    logic [7:0]            alu_res;
    logic                  alu_c, alu_dc, alu_bit;
    logic                  dest_file, take;
    logic [`SBB_PTR_W-1:0] offset_ext;

    // ---------------------------------------------
    // Datapath instance
    // ---------------------------------------------
    sbb_alu u_alu (
        .op         (instr_op),
        .acc        (acc_r),
        .fdata      (file_rdata),
        .bsel       (instr_word[`SBB_BIT_HI:`SBB_BIT_LO]),
        .carry_in   (c_r),
        .result     (alu_res),
        .carry_out  (alu_c),
        .nibble_out (alu_dc),
        .bit_val    (alu_bit)
    );

    // File address is combinational so the read data returns in the same cycle
    assign file_addr  = instr_word[`SBB_FADDR_HI:0];
    assign dest_file  = instr_word[`SBB_DEST_BIT];
    assign offset_ext = {{(`SBB_PTR_W-`SBB_OFF_W){instr_word[`SBB_OFF_HI]}},
                         instr_word[`SBB_OFF_HI:0]}; // RQ8

    // ---------------------------------------------
    // Next-state: execute and filler sequencing
    // ---------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        acc_nxt   = acc_r;
        c_nxt     = c_r;
        dc_nxt    = dc_r;
        z_nxt     = z_r;
        ptr_nxt   = ptr_r;
        ld_nxt    = 1'b0;
        disc_nxt  = 1'b0;
        we_nxt    = 1'b0;
        wd_nxt    = wd_r;
        take      = 1'b0;
        case (state_r)
            SBB_ST_RUN:
            begin
                if (instr_valid)
                begin
                    case (instr_op)
                        SBB_OP_ARITH_SHIFT_RIGHT_FILE, SBB_OP_ADD_WITH_CARRY_TO_FILE:
                        begin
                            c_nxt = alu_c;                                   // RQ1
                            z_nxt = (alu_res == `SBB_ZERO8);                 // RQ1
                            if (instr_op == SBB_OP_ADD_WITH_CARRY_TO_FILE)
                                dc_nxt = alu_dc;                             // RQ4
                            if (dest_file)
                            begin
                                we_nxt = 1'b1;                               // RQ3
                                wd_nxt = alu_res;
                            end
                            else
                                acc_nxt = alu_res;                           // RQ2
                        end
                        SBB_OP_BIT_CLEAR_FILE:
                        begin
                            we_nxt = 1'b1;                                   // RQ5
                            wd_nxt = alu_res;
                        end
                        SBB_OP_BIT_TEST_SKIP_CLEAR:
                            take = ~alu_bit;                                 // RQ6 RQ11
                        SBB_OP_BIT_TEST_SKIP_SET:
                            take = alu_bit;                                  // RQ7 RQ11
                        SBB_OP_RELATIVE_JUMP:
                        begin
                            ptr_nxt = instr_pointer_in + `SBB_ONE_PTR + offset_ext; // RQ8
                            ld_nxt  = 1'b1;
                            take    = 1'b1;                                  // RQ9
                        end
                        default:
                        begin
                            take = 1'b0;
                        end
                    endcase
                    if (take)
                    begin
                        disc_nxt  = 1'b1;        // RQ10
                        state_nxt = SBB_ST_FILL; // RQ10
                    end
                end
            end
            SBB_ST_FILL:
            begin
                state_nxt = SBB_ST_RUN; // Filler is a no-operation
            end
            default:
            begin
                state_nxt = SBB_ST_RUN;
            end
        endcase
    end

    // ---------------------------------------------
    // State registers
    // ---------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            state_r <= SBB_ST_RUN;
            acc_r   <= `SBB_ACC_RST;
            c_r     <= 1'b0;
            dc_r    <= 1'b0;
            z_r     <= 1'b0;
            ptr_r   <= `SBB_PTR_RST;
            ld_r    <= 1'b0;
            disc_r  <= 1'b0;
            we_r    <= 1'b0;
            wd_r    <= `SBB_ZERO8;
        end
        else
        begin
            state_r <= state_nxt;
            acc_r   <= acc_nxt;
            c_r     <= c_nxt;
            dc_r    <= dc_nxt;
            z_r     <= z_nxt;
            ptr_r   <= ptr_nxt;
            ld_r    <= ld_nxt;
            disc_r  <= disc_nxt;
            we_r    <= we_nxt;
            wd_r    <= wd_nxt;
        end
    end

    // Write strobe and data; the file side keeps the execute-cycle address
    assign file_we              = we_r;
    assign file_wdata           = wd_r;
    assign acc                  = acc_r;
    assign carry                = c_r;
    assign nibble_overflow_flag = dc_r;
    assign zero                 = z_r;
    assign instr_pointer        = ptr_r;
    assign instr_pointer_load   = ld_r;
    assign discard_next         = disc_r;
    assign stall_busy           = (state_r == SBB_ST_FILL);

    // ---------------------------------------------
    // Checks
    // ---------------------------------------------
    sequence s_jump_issued;
        state_r == SBB_ST_RUN && instr_valid && instr_op == SBB_OP_RELATIVE_JUMP;
    endsequence
    sequence s_fill_then_run;
        stall_busy ##1 !stall_busy;
    endsequence

    a_jump_two_cycles: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ9
        s_jump_issued |=> s_fill_then_run)
        else $error("Relative jump did not take two cycles");
    a_jump_target_val: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ8
        s_jump_issued |=> instr_pointer_load && instr_pointer ==
            $past(instr_pointer_in) + `SBB_ONE_PTR + $past(offset_ext))
        else $error("Relative jump target wrong");
    a_shift_keeps_msb: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ1
        (state_r == SBB_ST_RUN && instr_valid && instr_op == SBB_OP_ARITH_SHIFT_RIGHT_FILE
         && !dest_file) |=> acc[7] == $past(file_rdata[7]) && carry == $past(file_rdata[0]))
        else $error("Shift lost the top bit or carry");
    a_dest_file_write: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ3
        (state_r == SBB_ST_RUN && instr_valid && dest_file
         && instr_op == SBB_OP_ARITH_SHIFT_RIGHT_FILE) |=> file_we && $stable(acc))
        else $error("Shift to file did not write file");
    a_dest_acc_only: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ2
        (state_r == SBB_ST_RUN && instr_valid && !dest_file
         && instr_op == SBB_OP_ADD_WITH_CARRY_TO_FILE) |=> !file_we)
        else $error("Accumulator destination wrote the file");
    a_adc_sum_val: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ4
        (state_r == SBB_ST_RUN && instr_valid && !dest_file
         && instr_op == SBB_OP_ADD_WITH_CARRY_TO_FILE) |=>
        {carry, acc} == {1'b0, $past(acc)} + {1'b0, $past(file_rdata)} + {8'h00, $past(carry)})
        else $error("Add with carry sum wrong");
    a_bclr_target_bit: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ5
        (state_r == SBB_ST_RUN && instr_valid && instr_op == SBB_OP_BIT_CLEAR_FILE) |=>
        file_we && file_wdata[$past(instr_word[`SBB_BIT_HI:`SBB_BIT_LO])] == 1'b0)
        else $error("Bit clear did not clear bit");
    a_skip_clear_take: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ6
        (state_r == SBB_ST_RUN && instr_valid && instr_op == SBB_OP_BIT_TEST_SKIP_CLEAR)
        |=> discard_next == !$past(alu_bit))
        else $error("Skip-if-clear decision wrong");
    a_skip_set_take: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ7
        (state_r == SBB_ST_RUN && instr_valid && instr_op == SBB_OP_BIT_TEST_SKIP_SET)
        |=> discard_next == $past(alu_bit))
        else $error("Skip-if-set decision wrong");
    a_fill_one_cycle: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ10
        discard_next |-> stall_busy ##1 !stall_busy)
        else $error("Filler cycle not exactly one");
    a_flags_kept: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ11
        (state_r == SBB_ST_RUN && instr_valid && (instr_op == SBB_OP_BIT_CLEAR_FILE
         || instr_op == SBB_OP_BIT_TEST_SKIP_CLEAR
         || instr_op == SBB_OP_BIT_TEST_SKIP_SET || instr_op == SBB_OP_RELATIVE_JUMP))
        |=> $stable(carry) && $stable(zero) && $stable(nibble_overflow_flag))
        else $error("Flags changed by bit or jump op");
endmodule // sbb_core
`default_nettype wire

// ===== sbb_file_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Data register file seen by the core
// ----------------------------------------
module sbb_file_model
(
    input  wire logic       core_clk,
    input  wire logic [6:0] file_addr,
    input  wire logic       file_we,
    input  wire logic [7:0] file_wdata,
    output logic      [7:0] file_rdata
);
    logic [7:0] mem [0:127];
    logic [6:0] waddr_r;

    // Read is combinational for the address now shown
    assign file_rdata = mem[file_addr];

    // Write lands a cycle late, so the address is kept from the execute edge
    always @(posedge core_clk)
    begin
        if (file_we)
            mem[waddr_r] <= file_wdata;
        waddr_r <= file_addr;
    end

    // Known pattern, mirrored in the bench
    initial
    begin
        for (int i = 0; i < 128; i++)
            mem[i] = 8'(i * 37 + 5);
    end
endmodule // sbb_file_model
`default_nettype wire

// ===== shift_addc_bit_branch_ops_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "sbb_map.svh"
module shift_addc_bit_branch_ops_tb
    import sbb_pkg::*;
;
    logic core_clk, rst_b, instr_valid;
    sbb_op_t instr_op;
    logic [13:0] instr_word;
    logic [14:0] instr_pointer_in, instr_pointer;
    logic [7:0] file_rdata, file_wdata, acc;
    logic [6:0] file_addr;
    logic file_we, carry, nibble_overflow_flag, zero;
    logic instr_pointer_load, discard_next, stall_busy;
    int error_cnt, tests_run;
    logic [7:0] mem [0:127];
    logic [7:0] m_acc;
    logic m_c, m_dc, m_z;

    sbb_core DUT (.core_clk(core_clk), .rst_b(rst_b), .instr_valid(instr_valid),
        .instr_op(instr_op), .instr_word(instr_word), .instr_pointer_in(instr_pointer_in),
        .file_rdata(file_rdata), .file_addr(file_addr), .file_we(file_we),
        .file_wdata(file_wdata), .acc(acc), .carry(carry),
        .nibble_overflow_flag(nibble_overflow_flag), .zero(zero),
        .instr_pointer(instr_pointer), .instr_pointer_load(instr_pointer_load),
        .discard_next(discard_next), .stall_busy(stall_busy));
    sbb_file_model u_file (.core_clk(core_clk), .file_addr(file_addr), .file_we(file_we),
        .file_wdata(file_wdata), .file_rdata(file_rdata));

    // ----------------------------------------
    // Compare and report
    // ----------------------------------------
    task automatic chk1(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk15(input logic [14:0] got, input logic [14:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("Counts: tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // One instruction against the reference
    // ----------------------------------------
    task automatic exec(input sbb_op_t op, input logic [13:0] w, input logic [14:0] p);
        logic [7:0] f, r;
        logic [8:0] s;
        logic [14:0] ep;
        logic skip, we, ld;
        f = mem[w[6:0]];
        r = f;
        we = 1'b0;
        ld = 1'b0;
        skip = 1'b0;
        ep = p + 15'h0001 + {{6{w[8]}}, w[8:0]};
        case (op)
            SBB_OP_ARITH_SHIFT_RIGHT_FILE: r = {f[7], f[7:1]};
            SBB_OP_ADD_WITH_CARRY_TO_FILE:
            begin
                s = m_acc + f + 9'(m_c);
                m_dc = (5'(m_acc[3:0]) + 5'(f[3:0]) + 5'(m_c)) > 5'h0f;
                r = s[7:0];
            end
            SBB_OP_BIT_CLEAR_FILE: r[w[9:7]] = 1'b0;
            SBB_OP_BIT_TEST_SKIP_CLEAR: skip = !f[w[9:7]];
            SBB_OP_BIT_TEST_SKIP_SET: skip = f[w[9:7]];
            default:
            begin
                ld = 1'b1;
                skip = 1'b1;
            end
        endcase
        if (op == SBB_OP_ARITH_SHIFT_RIGHT_FILE || op == SBB_OP_ADD_WITH_CARRY_TO_FILE)
        begin
            m_c = (op == SBB_OP_ADD_WITH_CARRY_TO_FILE) ? s[8] : f[0];
            m_z = (r == 8'h00);
            we = w[7];
            if (!w[7])
                m_acc = r;
        end
        we = we | (op == SBB_OP_BIT_CLEAR_FILE);
        @(posedge core_clk);
        instr_valid <= 1'b1;
        instr_op <= op;
        instr_word <= w;
        instr_pointer_in <= p;
        @(posedge core_clk);
        // Held high into the filler cycle, where it must be ignored
        instr_valid <= skip;
        #1;
        chk8({1'b0, file_addr}, {1'b0, w[6:0]}, "read address");
        chk1(file_we, we, "write strobe");
        if (we)
        begin
            chk8(file_wdata, r, "write data");
            mem[w[6:0]] = r;
        end
        chk8(acc, m_acc, "acc");
        chk1(carry, m_c, "carry");
        chk1(nibble_overflow_flag, m_dc, "nibble");
        chk1(zero, m_z, "zero");
        chk1(instr_pointer_load, ld, "load");
        if (ld)
            chk15(instr_pointer, ep, "target");
        chk1(discard_next, skip, "discard");
        chk1(stall_busy, skip, "filler");
        if (skip)
        begin
            @(posedge core_clk);
            instr_valid <= 1'b0;
            #1;
            chk1(stall_busy, 1'b0, "filler end");
            chk1(file_we | instr_pointer_load, 1'b0, "refused");
        end
    endtask

    // ----------------------------------------
    // Clock and sequence
    // ----------------------------------------
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Cuts a hang short
    initial
    begin
        #(100 * 20000);
        error_cnt++;
        $display("BAD t=%0t watchdog expired", $time);
        give_verdict();
    end

    initial
    begin
        rst_b = 1'b0;
        instr_valid = 1'b0;
        instr_op = SBB_OP_NONE;
        instr_word = 14'h0000;
        instr_pointer_in = 15'h0000;
        error_cnt = 0;
        tests_run = 0;
        m_acc = 8'h00;
        {m_c, m_dc, m_z} = 3'b000;
        for (int i = 0; i < 128; i++)
            mem[i] = 8'(i * 37 + 5);
        void'($urandom(38068));
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        #1;
        for (int k = 0; k < 8 && stall_busy !== 1'b0; k++)
            @(posedge core_clk);
        chk1(stall_busy, 1'b0, "idle after reset");
        chk8(acc, 8'h00, "acc after reset");
        chk1(carry | zero | nibble_overflow_flag, 1'b0, "flags after reset");
        chk1(file_we | instr_pointer_load | discard_next, 1'b0, "strobes after reset");
        chk15(instr_pointer, 15'h0000, "pointer after reset");
        $display("test reset done, errors %0d", error_cnt);
        // Offset extremes and pointer wrap
        exec(SBB_OP_RELATIVE_JUMP, 14'h0100, 15'h0005);
        exec(SBB_OP_RELATIVE_JUMP, 14'h00ff, 15'h7fff);
        for (int b = 0; b < 8; b++)
        begin
            exec(SBB_OP_BIT_CLEAR_FILE, 14'(b << 7) | 14'h0003, 15'h0010);
            exec(SBB_OP_BIT_TEST_SKIP_CLEAR, 14'(b << 7) | 14'h0003, 15'h0011);
            exec(SBB_OP_BIT_TEST_SKIP_SET, 14'(b << 7) | 14'h0004, 15'h0012);
        end
        $display("test directed done, errors %0d", error_cnt);
        for (int i = 0; i < 600; i++)
            exec(sbb_op_t'(3'(1 + i % 6)), 14'($urandom), 15'($urandom));
        $display("test random done, errors %0d", error_cnt);
        // Reset in mid-run must clear accumulator and flags again
        @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        #1;
        chk8(acc, 8'h00, "acc after second reset");
        chk1(carry | zero | nibble_overflow_flag, 1'b0, "flags after second reset");
        chk1(stall_busy | discard_next | file_we, 1'b0, "strobes after second reset");
        m_acc = 8'h00;
        {m_c, m_dc, m_z} = 3'b000;
        exec(SBB_OP_ADD_WITH_CARRY_TO_FILE, 14'h0005, 15'h0000);
        exec(SBB_OP_RELATIVE_JUMP, 14'h01f0, 15'h0020);
        $display("test second reset done, errors %0d", error_cnt);
        give_verdict();
    end
endmodule // shift_addc_bit_branch_ops_tb
`default_nettype wire
